//--- pie_map.vh
// register offsets, bit positions and reset values for the peripheral enable block
`ifndef PIE_MAP_VH
`define PIE_MAP_VH
`define PIE_ADDR_ENABLE 8'h8c
`define PIE_ADDR_STATUS 8'h90
`define PIE_ADDR_MASK 8'h91
`define PIE_ADDR_CTRL 8'h92
`define PIE_BIT_TIMER1 0
`define PIE_BIT_TIMER2 1
`define PIE_BIT_CAPCOMP 2
`define PIE_BIT_SERIAL 3
`define PIE_BIT_TX 4
`define PIE_BIT_RX 5
`define PIE_BIT_RSVD 6
`define PIE_BIT_PARSLAVE 7
`define PIE_RESET_VALUE 8'h00
`define PIE_CTRL_GATE 0
`define PIE_VAR_BASIC 2'h0
`define PIE_VAR_USART 2'h1
`define PIE_VAR_PARSLAVE 2'h2
`define PIE_VAR_FULL 2'h3
`endif

//--- pie_enable.v
// peripheral interrupt enable register with gated combined request
`timescale 1ns/100ps
// What this block does
// - bit 0 gates timer1 overflow flag
// - bit 1 gates timer2 period match flag
// - bit 2 gates capture/compare flag
// - bit 3 gates serial port flag
// - usart variants: bit 5 gates receive flag
// - usart variants: bit 4 gates transmit flag
// - no usart: bits 5-4 read zero
// - reset clears every enable bit
// - parallel slave variants: bit 7 gates parallel slave flag
// - request needs peripheral gate bit too
// - flags set regardless of enables
`include "pie_map.vh"
module pie_enable #(
   parameter [1:0] VARIANT = `PIE_VAR_FULL
) (
   // clock and reset
   input wire sys_clk,
   input wire rst_n,
   // register port
   input wire [7:0] reg_addr,
   input wire [7:0] reg_wdata,
   input wire reg_wr,
   input wire reg_rd,
   output reg [7:0] reg_rdata,
   // peripheral flags, from logic on this clock
   input wire [7:0] periph_flags,
   // requests
   output reg periph_req,
   output reg irq
);
   localparam HAS_USART = (VARIANT == `PIE_VAR_USART) || (VARIANT == `PIE_VAR_FULL);
   localparam HAS_PARSLAVE = (VARIANT == `PIE_VAR_PARSLAVE) || (VARIANT == `PIE_VAR_FULL);

   reg rst_s1_reg;
   reg rst_s2_reg;
   wire rst_sync_n;
   reg [7:0] enable_reg;
   reg [7:0] enable_next;
   reg [7:0] status_reg;
   reg [7:0] status_next;
   reg [7:0] mask_reg;
   reg gate_reg;
   reg [7:0] flags_q_reg;
   reg [7:0] rdata_next;
   wire [7:0] impl_mask;
   wire [7:0] gated;
   wire [7:0] rise;

   always @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         rst_s1_reg <= 1'b0;
         rst_s2_reg <= 1'b0;
      end else begin
         rst_s1_reg <= 1'b1;
         rst_s2_reg <= rst_s1_reg;
      end
   end
   assign rst_sync_n = rst_s2_reg;

   // which bit positions exist in this build
   genvar i;
   generate
      for (i = 0; i < 8; i = i + 1) begin : g_impl
         if (i == `PIE_BIT_TX || i == `PIE_BIT_RX) begin : g_usart
            assign impl_mask[i] = HAS_USART ? 1'b1 : 1'b0;
         end else if (i == `PIE_BIT_PARSLAVE) begin : g_parslave
            assign impl_mask[i] = HAS_PARSLAVE ? 1'b1 : 1'b0;
         end else if (i == `PIE_BIT_RSVD) begin : g_rsvd
            assign impl_mask[i] = 1'b0;
         end else begin : g_base
            assign impl_mask[i] = 1'b1;
         end
         // flags pass through untouched; enables gate only the request
         assign gated[i] = periph_flags[i] & enable_reg[i];
      end
   endgenerate

   assign rise = periph_flags & ~flags_q_reg & impl_mask;

   always @* begin
      enable_next = enable_reg;
      if (reg_wr && reg_addr == `PIE_ADDR_ENABLE) begin
         // unimplemented and reserved positions never store
         enable_next = reg_wdata & impl_mask;
      end
   end

   // sticky status: a new edge wins over a write-one clear
   always @* begin
      status_next = status_reg;
      if (reg_wr && reg_addr == `PIE_ADDR_STATUS) begin
         status_next = status_reg & ~reg_wdata;
      end
      status_next = status_next | rise;
   end

   always @* begin
      rdata_next = 8'h00;
      if (reg_addr == `PIE_ADDR_ENABLE) begin
         rdata_next = enable_reg & impl_mask;
      end else if (reg_addr == `PIE_ADDR_STATUS) begin
         rdata_next = status_reg;
      end else if (reg_addr == `PIE_ADDR_MASK) begin
         rdata_next = mask_reg;
      end else if (reg_addr == `PIE_ADDR_CTRL) begin
         rdata_next = {7'h00, gate_reg};
      end
   end

   always @(posedge sys_clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         enable_reg <= `PIE_RESET_VALUE;
         status_reg <= 8'h00;
         mask_reg <= 8'h00;
         gate_reg <= 1'b0;
         flags_q_reg <= 8'h00;
         reg_rdata <= 8'h00;
         periph_req <= 1'b0;
         irq <= 1'b0;
      end else begin
         enable_reg <= enable_next;
         status_reg <= status_next;
         flags_q_reg <= periph_flags;
         if (reg_wr && reg_addr == `PIE_ADDR_MASK) begin
            mask_reg <= reg_wdata & impl_mask;
         end
         if (reg_wr && reg_addr == `PIE_ADDR_CTRL) begin
            gate_reg <= reg_wdata[`PIE_CTRL_GATE];
         end
         reg_rdata <= reg_rd ? rdata_next : 8'h00;
         periph_req <= gate_reg & (|(gated & impl_mask));
         irq <= |(status_next & mask_reg);
      end
   end
endmodule

//--- pie_enable_sva.sv
// assertions for the peripheral enable block
`timescale 1ns/100ps
module pie_enable_sva #(parameter [1:0] VARIANT = 2'h3) (
   input wire sys_clk, rst_n, reg_wr, reg_rd, periph_req, irq,
   input wire [7:0] reg_addr, reg_wdata, reg_rdata, periph_flags);
// shadow of the enable byte; reserved bit 6 never stores
localparam [7:0] M = {VARIANT[1], 1'b0, {2{VARIANT[0]}}, 4'hf};
reg [7:0] e;
reg g;
always @(posedge sys_clk or negedge rst_n) begin
   if (!rst_n) begin
      e <= 8'h00;
      g <= 1'b0;
   end else if (reg_wr && reg_addr == 8'h8c) e <= reg_wdata & M;
   else if (reg_wr && reg_addr == 8'h92) g <= reg_wdata[0];
end
default clocking @(posedge sys_clk); endclocking
default disable iff (!rst_n);
AST_T1: assert property ($past(g & e[0] & periph_flags[0]) |-> periph_req) else $error("b0");
AST_T2: assert property ($past(g & e[1] & periph_flags[1]) |-> periph_req) else $error("b1");
AST_CC: assert property ($past(g & e[2] & periph_flags[2]) |-> periph_req) else $error("b2");
AST_SS: assert property ($past(g & e[3] & periph_flags[3]) |-> periph_req) else $error("b3");
AST_TX: assert property ($past(g & e[4] & periph_flags[4]) |-> periph_req) else $error("b4");
AST_RX: assert property ($past(g & e[5] & periph_flags[5]) |-> periph_req) else $error("b5");
AST_PS: assert property ($past(g & e[7] & periph_flags[7]) |-> periph_req) else $error("b7");
AST_REQ: assert property (periph_req |-> $past(g & |(e & periph_flags))) else $error("req");
AST_RD: assert property ($past(reg_rd && reg_addr == 8'h8c) |-> reg_rdata == $past(e))
   else $error("rd");
endmodule
bind pie_enable pie_enable_sva #(.VARIANT(VARIANT)) pie_enable_sva_inst (.sys_clk, .rst_n,
   .reg_wr, .reg_rd, .periph_req, .irq, .reg_addr, .reg_wdata, .reg_rdata, .periph_flags);

//--- pie_enable_test.sv
// self-checking bench for the peripheral enable block
`timescale 1ns/100ps
module pie_enable_test;
reg sys_clk = 0, rst_n = 0, reg_wr = 0, reg_rd = 0;
reg [7:0] reg_addr = 0, reg_wdata = 0, periph_flags = 0;
wire [7:0] reg_rdata;
wire periph_req, irq;
integer error_cnt = 0, check_count = 0, i;
always #12.5 sys_clk = ~sys_clk;
pie_enable pie_enable_inst (.sys_clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
   .reg_rdata, .periph_flags, .periph_req, .irq);
task chk(input [8*5:1] n, input [7:0] x, input [7:0] y); begin
   check_count = check_count + 1;
   if (y !== x) begin
      error_cnt = error_cnt + 1;
      $display("ERROR %0s exp %h got %h", n, x, y);
   end
end endtask
task wr(input [7:0] a, input [7:0] d); begin
   @(posedge sys_clk);
   reg_addr <= a;
   reg_wdata <= d;
   reg_wr <= 1;
   @(posedge sys_clk);
   reg_wr <= 0;
   #1;
end endtask
task rd(input [7:0] a, input [7:0] x); begin
   @(posedge sys_clk);
   reg_addr <= a;
   reg_rd <= 1;
   @(posedge sys_clk);
   reg_rd <= 0;
   #1 chk("rdata", x, reg_rdata);
end endtask
// flags change on an edge, results settle one edge later
task fl(input [7:0] f); begin
   @(posedge sys_clk);
   periph_flags <= f;
   @(posedge sys_clk);
   #1;
end endtask
task t_reset; begin
   rd(8'h8c, 8'h00);
   rd(8'h55, 8'h00);
end endtask
task t_bits; begin
   wr(8'h8c, 8'hbf);
   rd(8'h8c, 8'hbf);
   fl(8'hff);
   chk("req", 0, periph_req);
   wr(8'h92, 8'h01);
   for (i = 0; i < 8; i = i + 1) begin
      wr(8'h8c, (i == 6) ? 8'h00 : (8'h01 << i));
      fl(8'h01 << i);
      chk("req", i != 6, periph_req);
      fl(~(8'h01 << i));
      chk("req", 0, periph_req);
   end
end endtask
task t_irq; begin
   fl(0);
   wr(8'h91, 8'h01);
   fl(1);
   chk("irq", 1, irq);
   wr(8'h90, 8'h01);
   chk("irq", 0, irq);
   wr(8'h91, 8'h00);
   fl(0);
   fl(1);
   chk("irq", 0, irq);
end endtask
task final_report; begin
   if (error_cnt == 0 && check_count > 0) $display("TEST PASSED");
   else $display("TEST FAILED");
   $finish;
end endtask
initial begin
   repeat (4) @(posedge sys_clk);
   rst_n <= 1;
   repeat (3) @(posedge sys_clk);
   t_reset;
   t_bits;
   t_irq;
   final_report;
end
initial begin
   #20000 error_cnt = error_cnt + 1;
   final_report;
end
endmodule
